// *** design/rca_top.sv ***
/*
  rca_top: calendar timekeeping and first-alarm registers behind an apb
  slave, with sticky interrupt status, mask and one level interrupt.
  assumes: sec_tick_pin is an asynchronous one-hertz square wave from the
  timebase; pclk runs at 200 MHz; software writes valid bcd values.
*/
// What this block does
// - minutes are kept as bcd with tens in bits 6:4 and units in bits 3:0.
// - hours bit 6 selects 24-hour counting 0..23 when clear, 1..12 when set.
// - hours bit 5 is the pm flag in 12-hour mode and the twenties digit else.
// - the hour is bcd with its tens digit in bit 4 and units in bits 3:0.
// - the date is bcd with two tens bits 5:4 and four units bits 3:0.
// - month bit 7 is the century flag, clear for 21st and set for 22nd.
// - the month is bcd with one tens bit 4 and four units bits 3:0.
// - the year is two bcd digits, tens in bits 7:4 and units in bits 3:0.
// - alarm one seconds bit 7 masks the seconds out of the comparison.
// - alarm one seconds compare value is bcd in bits 6:4 and 3:0.
// - alarm one minutes bit 7 masks the minutes out of the comparison.
// - alarm one minutes compare value is bcd in bits 6:4 and 3:0.
// - the weekday is three bits 2:0 and resets to one.
// - alarm one day/date bit 6 compares the weekday when set, date if clear.
`timescale 1ns/1ps
module rca_top
  import rca_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  rca_pkg::rca_apb_req_t apb_req,
  output rca_pkg::rca_apb_rsp_t apb_rsp,
  // timebase and interrupt
  input  wire logic          sec_tick_pin,
  output logic               irq
);

  // ==========================================================================
  // state
  // ==========================================================================
  rca_state_t st_reg;
  rca_state_t st_next;
  rca_time_t  tm_stepped;

  // ==========================================================================
  // calendar step
  // ==========================================================================
  rca_cal_inc u_cal_inc (
    .cur (st_reg.tm),
    .nxt (tm_stepped)
  );

  // ==========================================================================
  // register read mux: bit 8 flags a mapped index
  // ==========================================================================
  function automatic logic [8:0] read_reg(input logic [9:0]  idx,
                                          input rca_state_t s);
    case (idx)
      RCA_IDX_IRQ_STATUS:   return {1'b1, s.irq_status};
      RCA_IDX_IRQ_MASK:     return {1'b1, s.irq_mask};
      RCA_IDX_SECONDS:      return {1'b1, s.tm.sec};
      RCA_IDX_MINUTES:      return {1'b1, s.tm.min};
      RCA_IDX_HOURS:        return {1'b1, s.tm.hour};
      RCA_IDX_WEEKDAY:      return {1'b1, s.tm.wday};
      RCA_IDX_DATE:         return {1'b1, s.tm.date};
      RCA_IDX_MONTH:        return {1'b1, s.tm.month};
      RCA_IDX_YEAR:         return {1'b1, s.tm.year};
      RCA_IDX_ALM1_SECONDS: return {1'b1, s.alm.sec};
      RCA_IDX_ALM1_MINUTES: return {1'b1, s.alm.min};
      RCA_IDX_ALM1_HOURS:   return {1'b1, s.alm.hours};
      RCA_IDX_ALM1_DAYDATE: return {1'b1, s.alm.daydate};
      default:              return {1'b0, RCA_RST_ZERO};
    endcase
  endfunction : read_reg

  // ==========================================================================
  // combinational next state
  // ==========================================================================
  logic [9:0] idx;
  logic       addr_ok;
  logic [8:0] rd;
  logic       setup;
  logic       wr_en;
  logic [7:0] wdata;
  logic       tick;
  logic       m_sec;
  logic       m_min;
  logic       m_hrs;
  logic       m_day;
  logic       alarm_hit;
  logic [7:0] irq_set;
  logic [7:0] irq_clr;

  always_comb begin
    st_next = st_reg;

    // ------------------------------------------------------------------
    // apb decode: word aligned, unmapped indices answer with pslverr
    // ------------------------------------------------------------------
    idx     = apb_req.paddr[11:2];
    addr_ok = (apb_req.paddr[1:0] == 2'b00);
    rd      = read_reg(idx, st_reg);
    setup   = apb_req.psel && !apb_req.penable && !st_reg.rsp.pready;
    wr_en   = apb_req.psel && apb_req.penable && st_reg.rsp.pready &&
              apb_req.pwrite && !st_reg.rsp.pslverr;
    wdata   = apb_req.pwdata[7:0];

    // one wait-free answer: pready rises in the first access cycle
    st_next.rsp.pready  = setup;
    st_next.rsp.pslverr = setup && !(addr_ok && rd[8]);
    if (setup) begin
      st_next.rsp.prdata = (addr_ok && !apb_req.pwrite)
                           ? {24'h000000, rd[7:0]} : 32'h00000000;
    end else begin
      st_next.rsp.prdata = 32'h00000000;
    end

    // ------------------------------------------------------------------
    // one-second tick: three flops, level accepted when last two agree
    // ------------------------------------------------------------------
    st_next.tick_sync = {st_reg.tick_sync[1:0], sec_tick_pin};
    tick = 1'b0;
    if (st_reg.tick_sync[1] == st_reg.tick_sync[2]) begin
      st_next.tick_level = st_reg.tick_sync[2];
      tick = st_reg.tick_sync[2] && !st_reg.tick_level;
    end
    st_next.tick_done = tick;

    // ------------------------------------------------------------------
    // timekeeping: tick steps the calendar, a write then overrides
    // ------------------------------------------------------------------
    if (tick) begin
      st_next.tm = tm_stepped;
    end

    if (wr_en) begin
      case (idx)
        RCA_IDX_SECONDS: begin
          st_next.tm.sec = wdata & RCA_WMASK_SECONDS;
        end
        RCA_IDX_MINUTES: begin
          st_next.tm.min = wdata & RCA_WMASK_MINUTES;
        end
        RCA_IDX_HOURS: begin
          st_next.tm.hour = wdata & RCA_WMASK_HOURS;
        end
        RCA_IDX_WEEKDAY: begin
          st_next.tm.wday = wdata & RCA_WMASK_WEEKDAY;
        end
        RCA_IDX_DATE: begin
          st_next.tm.date = wdata & RCA_WMASK_DATE;
        end
        RCA_IDX_MONTH: begin
          st_next.tm.month = wdata & RCA_WMASK_MONTH;
        end
        RCA_IDX_YEAR: begin
          st_next.tm.year = wdata & RCA_WMASK_YEAR;
        end
        RCA_IDX_ALM1_SECONDS: begin
          st_next.alm.sec = wdata & RCA_WMASK_FULL;
        end
        RCA_IDX_ALM1_MINUTES: begin
          st_next.alm.min = wdata & RCA_WMASK_FULL;
        end
        RCA_IDX_ALM1_HOURS: begin
          st_next.alm.hours = wdata & RCA_WMASK_ALM_HRS;
        end
        RCA_IDX_ALM1_DAYDATE: begin
          st_next.alm.daydate = wdata & RCA_WMASK_FULL;
        end
        RCA_IDX_IRQ_MASK: begin
          st_next.irq_mask = wdata & RCA_WMASK_IRQ;
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------------
    // alarm one compare, judged once on the settled time after a tick
    // ------------------------------------------------------------------
    m_sec = st_reg.alm.sec[RCA_ALM_MASK_BIT] ||
            ((st_reg.alm.sec & RCA_CMP_SECMIN) ==
             (st_reg.tm.sec & RCA_CMP_SECMIN));
    m_min = st_reg.alm.min[RCA_ALM_MASK_BIT] ||
            ((st_reg.alm.min & RCA_CMP_SECMIN) ==
             (st_reg.tm.min & RCA_CMP_SECMIN));
    m_hrs = st_reg.alm.hours[RCA_ALM_MASK_BIT] ||
            ((st_reg.alm.hours & RCA_CMP_HOURS) ==
             (st_reg.tm.hour & RCA_CMP_HOURS));
    if (st_reg.alm.daydate[RCA_ALM_MASK_BIT]) begin
      m_day = 1'b1;
    end else if (st_reg.alm.daydate[RCA_ALM_WDAY_SEL]) begin
      m_day = ((st_reg.alm.daydate & RCA_CMP_WDAY) ==
               (st_reg.tm.wday & RCA_CMP_WDAY));
    end else begin
      m_day = ((st_reg.alm.daydate & RCA_CMP_DATE) ==
               (st_reg.tm.date & RCA_CMP_DATE));
    end
    alarm_hit = st_reg.tick_done && m_sec && m_min && m_hrs && m_day;

    // ------------------------------------------------------------------
    // sticky status: write one to clear, a same-cycle set wins
    // ------------------------------------------------------------------
    irq_set = RCA_RST_ZERO;
    irq_set[RCA_IRQ_ALARM_BIT] = alarm_hit;
    irq_set[RCA_IRQ_TICK_BIT]  = st_reg.tick_done;
    irq_clr = RCA_RST_ZERO;
    if (wr_en && (idx == RCA_IDX_IRQ_STATUS)) begin
      irq_clr = wdata & RCA_WMASK_IRQ;
    end
    st_next.irq_status = (st_reg.irq_status & ~irq_clr) | irq_set;
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.tm.sec       <= RCA_RST_ZERO;
      st_reg.tm.min       <= RCA_RST_ZERO;
      st_reg.tm.hour      <= RCA_RST_ZERO;
      st_reg.tm.wday      <= RCA_RST_ONE;
      st_reg.tm.date      <= RCA_RST_ONE;
      st_reg.tm.month     <= RCA_RST_ONE;
      st_reg.tm.year      <= RCA_RST_ZERO;
      st_reg.alm.sec      <= RCA_RST_ZERO;
      st_reg.alm.min      <= RCA_RST_ZERO;
      st_reg.alm.hours    <= RCA_RST_ZERO;
      st_reg.alm.daydate  <= RCA_RST_ZERO;
      st_reg.irq_status   <= RCA_RST_ZERO;
      st_reg.irq_mask     <= RCA_RST_ZERO;
      st_reg.tick_sync    <= 3'b000;
      st_reg.tick_level   <= 1'b0;
      st_reg.tick_done    <= 1'b0;
      st_reg.rsp.prdata   <= 32'h00000000;
      st_reg.rsp.pready   <= 1'b0;
      st_reg.rsp.pslverr  <= 1'b0;
      st_reg.irq          <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // outputs straight from flops
  // ==========================================================================
  assign apb_rsp = st_reg.rsp;
  assign irq     = st_reg.irq;

endmodule : rca_top

// *** common/rca_pkg.sv ***
/*
  rca_pkg: shared constants and types for the calendar and first-alarm
  register block: register indices, field positions and masks, reset
  values, bcd limits, apb carrier structs and the block state struct.
  assumes: the apb slave decodes word addresses (byte address = 4*index).
*/
package rca_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [9:0] RCA_IDX_IRQ_STATUS   = 10'h001;
  localparam logic [9:0] RCA_IDX_IRQ_MASK     = 10'h002;
  localparam logic [9:0] RCA_IDX_SECONDS      = 10'h009;
  localparam logic [9:0] RCA_IDX_MINUTES      = 10'h00A;
  localparam logic [9:0] RCA_IDX_HOURS        = 10'h00B;
  localparam logic [9:0] RCA_IDX_WEEKDAY      = 10'h00C;
  localparam logic [9:0] RCA_IDX_DATE         = 10'h00D;
  localparam logic [9:0] RCA_IDX_MONTH        = 10'h00E;
  localparam logic [9:0] RCA_IDX_YEAR         = 10'h00F;
  localparam logic [9:0] RCA_IDX_ALM1_SECONDS = 10'h010;
  localparam logic [9:0] RCA_IDX_ALM1_MINUTES = 10'h011;
  localparam logic [9:0] RCA_IDX_ALM1_HOURS   = 10'h012;
  localparam logic [9:0] RCA_IDX_ALM1_DAYDATE = 10'h013;

  // ==========================================================================
  // writable masks of each register, reserved bits read zero
  // ==========================================================================
  localparam logic [7:0] RCA_WMASK_SECONDS = 8'h7F;
  localparam logic [7:0] RCA_WMASK_MINUTES = 8'h7F;
  localparam logic [7:0] RCA_WMASK_HOURS   = 8'h7F;
  localparam logic [7:0] RCA_WMASK_WEEKDAY = 8'h07;
  localparam logic [7:0] RCA_WMASK_DATE    = 8'h3F;
  localparam logic [7:0] RCA_WMASK_MONTH   = 8'h9F;
  localparam logic [7:0] RCA_WMASK_YEAR    = 8'hFF;
  localparam logic [7:0] RCA_WMASK_ALM_HRS = 8'hBF;
  localparam logic [7:0] RCA_WMASK_FULL    = 8'hFF;
  localparam logic [7:0] RCA_WMASK_IRQ     = 8'h03;

  // ==========================================================================
  // field positions and compare masks
  // ==========================================================================
  localparam int RCA_HOUR_FMT_BIT    = 6;
  localparam int RCA_HOUR_PM_BIT     = 5;
  localparam int RCA_CENTURY_BIT     = 7;
  localparam int RCA_ALM_MASK_BIT    = 7;
  localparam int RCA_ALM_WDAY_SEL    = 6;
  localparam int RCA_IRQ_ALARM_BIT   = 0;
  localparam int RCA_IRQ_TICK_BIT    = 1;
  localparam logic [7:0] RCA_CMP_SECMIN = 8'h7F;
  localparam logic [7:0] RCA_CMP_HOURS  = 8'h3F;
  localparam logic [7:0] RCA_CMP_WDAY   = 8'h0F;
  localparam logic [7:0] RCA_CMP_DATE   = 8'h3F;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] RCA_RST_ZERO  = 8'h00;
  localparam logic [7:0] RCA_RST_ONE   = 8'h01;

  // ==========================================================================
  // bcd limits
  // ==========================================================================
  localparam logic [3:0] RCA_BCD_NINE   = 4'h9;
  localparam logic [3:0] RCA_BCD_STEP   = 4'h1;
  localparam logic [7:0] RCA_BCD_SEC_LAST = 8'h59;
  localparam logic [7:0] RCA_BCD_H24_LAST = 8'h23;
  localparam logic [7:0] RCA_BCD_H12_TOP  = 8'h12;
  localparam logic [7:0] RCA_BCD_H12_PRE  = 8'h11;
  localparam logic [7:0] RCA_BCD_WDAY_LAST = 8'h07;
  localparam logic [7:0] RCA_BCD_MON_LAST  = 8'h12;
  localparam logic [7:0] RCA_BCD_YEAR_LAST = 8'h99;
  localparam logic [7:0] RCA_BCD_FEB = 8'h02;
  localparam logic [7:0] RCA_BCD_APR = 8'h04;
  localparam logic [7:0] RCA_BCD_JUN = 8'h06;
  localparam logic [7:0] RCA_BCD_SEP = 8'h09;
  localparam logic [7:0] RCA_BCD_NOV = 8'h11;
  localparam logic [7:0] RCA_BCD_D28 = 8'h28;
  localparam logic [7:0] RCA_BCD_D29 = 8'h29;
  localparam logic [7:0] RCA_BCD_D30 = 8'h30;
  localparam logic [7:0] RCA_BCD_D31 = 8'h31;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rca_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rca_apb_rsp_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } rca_time_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hours;
    logic [7:0] daydate;
  } rca_alarm_t;

  typedef struct packed {
    rca_time_t    tm;
    rca_alarm_t   alm;
    logic [7:0]   irq_status;
    logic [7:0]   irq_mask;
    logic [2:0]   tick_sync;
    logic         tick_level;
    logic         tick_done;
    rca_apb_rsp_t rsp;
    logic         irq;
  } rca_state_t;

endpackage : rca_pkg

// *** design/rca_cal_inc.sv ***
/*
  rca_cal_inc: combinational one-second step of the bcd calendar.
  assumes: the current time holds valid bcd values in range.
*/
`timescale 1ns/1ps
module rca_cal_inc
  import rca_pkg::*;
(
  // current and stepped time
  input  rca_pkg::rca_time_t cur,
  output rca_pkg::rca_time_t nxt
);

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == RCA_BCD_NINE) begin
      return {v[7:4] + RCA_BCD_STEP, 4'h0};
    end
    return {v[7:4], v[3:0] + RCA_BCD_STEP};
  endfunction : bcd_inc

  logic       sec_wrap;
  logic       min_wrap;
  logic       day_wrap;
  logic       date_wrap;
  logic       mon_wrap;
  logic       h12_mode;
  logic       leap;
  logic [1:0] year_mod4;
  logic [7:0] h24;
  logic [7:0] h12;
  logic [7:0] mon_bcd;
  logic [7:0] month_days;
  logic [7:0] h24_inc;
  logic [7:0] h12_inc;
  logic [7:0] mon_inc;

  always_comb begin
    nxt = cur;
    // seconds into minutes into hours
    sec_wrap = (cur.sec == RCA_BCD_SEC_LAST);
    min_wrap = sec_wrap && (cur.min == RCA_BCD_SEC_LAST);
    nxt.sec  = sec_wrap ? RCA_RST_ZERO : bcd_inc(cur.sec);
    if (sec_wrap) begin
      nxt.min = (cur.min == RCA_BCD_SEC_LAST) ? RCA_RST_ZERO
                                              : bcd_inc(cur.min);
    end
    h12_mode = cur.hour[RCA_HOUR_FMT_BIT];
    h24      = cur.hour & RCA_CMP_HOURS;
    h12      = {3'b000, cur.hour[4:0]};
    h24_inc  = bcd_inc(h24);
    h12_inc  = bcd_inc(h12);
    day_wrap = 1'b0;
    if (min_wrap) begin
      if (!h12_mode) begin
        day_wrap = (h24 == RCA_BCD_H24_LAST);
        nxt.hour[5:0] = day_wrap ? 6'h00 : h24_inc[5:0];
      end else if (h12 == RCA_BCD_H12_TOP) begin
        nxt.hour[4:0] = RCA_RST_ONE[4:0];
      end else if (h12 == RCA_BCD_H12_PRE) begin
        nxt.hour[4:0] = RCA_BCD_H12_TOP[4:0];
        nxt.hour[RCA_HOUR_PM_BIT] = ~cur.hour[RCA_HOUR_PM_BIT];
        day_wrap = cur.hour[RCA_HOUR_PM_BIT];
      end else begin
        nxt.hour[4:0] = h12_inc[4:0];
      end
    end
    // days of the month, leap years and century
    year_mod4 = {cur.year[4], 1'b0} + cur.year[1:0];
    leap = (year_mod4 == 2'b00) &&
           !((cur.year == RCA_RST_ZERO) && cur.month[RCA_CENTURY_BIT]);
    // month digits only: century and reserved bits dropped
    mon_bcd = cur.month & RCA_WMASK_MONTH & RCA_CMP_DATE;
    mon_inc = bcd_inc(mon_bcd);
    case (mon_bcd)
      RCA_BCD_FEB: month_days = leap ? RCA_BCD_D29 : RCA_BCD_D28;
      RCA_BCD_APR,
      RCA_BCD_JUN,
      RCA_BCD_SEP,
      RCA_BCD_NOV: month_days = RCA_BCD_D30;
      default:     month_days = RCA_BCD_D31;
    endcase
    date_wrap = day_wrap && (cur.date == month_days);
    mon_wrap  = date_wrap && (mon_bcd == RCA_BCD_MON_LAST);
    if (day_wrap) begin
      nxt.wday = (cur.wday == RCA_BCD_WDAY_LAST) ? RCA_RST_ONE
                                                 : bcd_inc(cur.wday);
      nxt.date = date_wrap ? RCA_RST_ONE : bcd_inc(cur.date);
    end
    if (date_wrap) begin
      nxt.month[4:0] = mon_wrap ? RCA_RST_ONE[4:0]
                                : mon_inc[4:0];
    end
    if (mon_wrap) begin
      nxt.year = (cur.year == RCA_BCD_YEAR_LAST) ? RCA_RST_ZERO
                                                 : bcd_inc(cur.year);
      if (cur.year == RCA_BCD_YEAR_LAST) begin
        nxt.month[RCA_CENTURY_BIT] = ~cur.month[RCA_CENTURY_BIT];
      end
    end
  end

endmodule : rca_cal_inc

// *** verification/rca_top_asserts.sv ***
/*
  rca_top_asserts: port-level checks of the apb answer and register layout.
  assumes: bound to rca_top; zero-wait apb slave, data in bits 7:0.
*/
`timescale 1ns/1ps
module rca_top_asserts
  import rca_pkg::*;
(
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // watched ports
  input rca_pkg::rca_apb_req_t apb_req,
  input rca_pkg::rca_apb_rsp_t apb_rsp,
  input wire logic       sec_tick_pin,
  input wire logic       irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       rd;
  logic [9:0] ix;
  logic [31:0] d;
  assign rd = apb_rsp.pready & apb_req.psel & ~apb_req.pwrite;
  assign ix = apb_req.paddr[11:2];
  assign d  = apb_rsp.prdata;
  // ==========================================================================
  // apb answer
  // ==========================================================================
  property p_ready_one;
    apb_req.psel && !apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("no answer");
  property p_ready_pulse;
    apb_rsp.pready |=> !apb_rsp.pready ##1 !apb_rsp.pready || apb_req.psel;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  property p_idle_zero;
    !apb_rsp.pready |-> d == 32'h0 && !apb_rsp.pslverr;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle data");
  // ==========================================================================
  // field layout on read
  // ==========================================================================
  property p_min_fmt;
    rd && ix == RCA_IDX_MINUTES |-> d[31:7] == '0;
  endproperty
  a_min_fmt: assert property (p_min_fmt) else $error("minutes bits");
  property p_hour_fmt;
    rd && ix == RCA_IDX_HOURS |-> d[31:7] == '0;
  endproperty
  a_hour_fmt: assert property (p_hour_fmt) else $error("hour bits");
  property p_wday_fmt;
    rd && ix == RCA_IDX_WEEKDAY |-> d[31:3] == '0 && d[2:0] != 3'h0;
  endproperty
  a_wday_fmt: assert property (p_wday_fmt) else $error("weekday bits");
  property p_date_fmt;
    rd && ix == RCA_IDX_DATE |-> d[31:6] == '0;
  endproperty
  a_date_fmt: assert property (p_date_fmt) else $error("date bits");
  property p_mon_fmt;
    rd && ix == RCA_IDX_MONTH |-> d[31:8] == '0 && d[6:5] == 2'h0;
  endproperty
  a_mon_fmt: assert property (p_mon_fmt) else $error("month bits");
  property p_year_fmt;
    rd && ix == RCA_IDX_YEAR |-> d[31:8] == '0 && !apb_rsp.pslverr;
  endproperty
  a_year_fmt: assert property (p_year_fmt) else $error("year bits");
  property p_alm_fmt;
    rd && (ix == RCA_IDX_ALM1_SECONDS || ix == RCA_IDX_ALM1_MINUTES)
      |-> d[31:8] == '0;
  endproperty
  a_alm_fmt: assert property (p_alm_fmt) else $error("alarm bits");
endmodule : rca_top_asserts

bind rca_top rca_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .sec_tick_pin(sec_tick_pin),
  .irq(irq));

// *** verification/rca_top_tb_top.sv ***
/*
  rca_top_tb_top: self-checking bench for the calendar and alarm registers.
  assumes: zero-wait apb answer; a tick is accepted within a few cycles.
*/
`timescale 1ns/1ps
module rca_top_tb_top;
  import rca_pkg::*;
  logic         pclk, presetn, tick_pin, irq;
  rca_apb_req_t req;
  rca_apb_rsp_t rsp;
  logic [32:0]  exp_q[$];
  logic [31:0]  seed = 32'h0000002E;
  logic [31:0]  r;
  int           bad_count, compares;
  logic [9:0] ix_t[8] = '{RCA_IDX_MINUTES, RCA_IDX_HOURS, RCA_IDX_WEEKDAY,
    RCA_IDX_DATE, RCA_IDX_MONTH, RCA_IDX_YEAR, RCA_IDX_ALM1_SECONDS,
    RCA_IDX_ALM1_MINUTES};
  logic [7:0] rs_t[8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00,
    8'h00};
  logic [7:0] wm_t[8] = '{RCA_WMASK_MINUTES, RCA_WMASK_HOURS,
    RCA_WMASK_WEEKDAY, RCA_WMASK_DATE, RCA_WMASK_MONTH, RCA_WMASK_YEAR,
    RCA_WMASK_FULL, RCA_WMASK_FULL};
  rca_top uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .sec_tick_pin(tick_pin), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [32:0] got, input logic [32:0] x);
    compares++;
    if (got !== x) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, x);
    end
  endtask : chk
  task give_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // read answers are compared against the oldest note
  always @(posedge pclk) begin
    if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && req.psel === 1'b1)
      chk({rsp.pslverr, rsp.prdata}, exp_q.pop_front());
  end
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  task automatic apb(input logic w, input logic [9:0] ix,
                     input logic [7:0] d, input logic [32:0] x);
    @(posedge pclk);
    req <= {1'b1, 1'b0, w, ix, 2'b00, xs() & 32'hFFFFFF00 | {24'h0, d}};
    if (!w) exp_q.push_back(x);
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    req <= '0;
  endtask : apb
  task automatic rd(input logic [9:0] ix, input logic [32:0] x);
    apb(1'b0, ix, 8'h00, x);
  endtask : rd
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d, '0);
  endtask : wr
  task automatic tick();
    @(posedge pclk) tick_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    tick_pin <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask : tick
  task automatic step(input logic [7:0] h, d, m, y, eh, ed, em, ey);
    wr(RCA_IDX_SECONDS, 8'h59);
    wr(RCA_IDX_MINUTES, 8'h59);
    wr(RCA_IDX_HOURS, h);
    wr(RCA_IDX_DATE, d);
    wr(RCA_IDX_MONTH, m);
    wr(RCA_IDX_YEAR, y);
    tick();
    rd(RCA_IDX_MINUTES, 33'h0);
    rd(RCA_IDX_HOURS, {25'h0, eh});
    rd(RCA_IDX_DATE, {25'h0, ed});
    rd(RCA_IDX_MONTH, {25'h0, em});
    rd(RCA_IDX_YEAR, {25'h0, ey});
    $display("test step done");
  endtask : step
  task automatic alm(input logic [7:0] s, m, dd, input logic mk,
                     input logic [32:0] st);
    wr(RCA_IDX_ALM1_SECONDS, s);
    wr(RCA_IDX_ALM1_MINUTES, m);
    wr(RCA_IDX_ALM1_DAYDATE, dd);
    wr(RCA_IDX_IRQ_MASK, {7'h0, mk});
    wr(RCA_IDX_IRQ_STATUS, 8'h03);
    wr(RCA_IDX_SECONDS, 8'h05);
    chk({32'h0, irq}, 33'h0);
    tick();
    rd(RCA_IDX_IRQ_STATUS, st);
    chk({32'h0, irq}, {32'h0, st[0] & mk});
    $display("test alarm done");
  endtask : alm
  initial begin
    presetn = 1'b0;
    req = '0;
    tick_pin = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ix_t[i], {25'h0, rs_t[i]});
    rd(10'h03F, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) begin
      r = xs();
      if (ix_t[i] == RCA_IDX_WEEKDAY) r[2:0] = r[2:0] | 3'h1;
      wr(ix_t[i], r[7:0]);
      rd(ix_t[i], {25'h0, r[7:0] & wm_t[i]});
    end
    $display("test registers done");
    wr(RCA_IDX_WEEKDAY, 8'h07);
    wr(RCA_IDX_ALM1_HOURS, 8'h80);
    step(8'h23, 8'h31, 8'h12, 8'h99, 8'h00, 8'h01, 8'h81, 8'h00);
    rd(RCA_IDX_WEEKDAY, 33'h1);
    step(8'h51, 8'h28, 8'h02, 8'h24, 8'h72, 8'h28, 8'h02, 8'h24);
    step(8'h71, 8'h28, 8'h02, 8'h23, 8'h52, 8'h01, 8'h03, 8'h23);
    step(8'h23, 8'h28, 8'h02, 8'h24, 8'h00, 8'h29, 8'h02, 8'h24);
    step(8'h23, 8'h30, 8'h11, 8'h24, 8'h00, 8'h01, 8'h12, 8'h24);
    alm(8'h06, 8'h80, 8'h80, 1'b1, 33'h3);
    alm(8'h06, 8'h45, 8'h80, 1'b1, 33'h2);
    alm(8'h80, 8'h00, 8'h80, 1'b1, 33'h3);
    alm(8'h80, 8'h80, 8'h44, 1'b1, 33'h3);
    alm(8'h80, 8'h80, 8'h04, 1'b1, 33'h2);
    alm(8'h06, 8'h80, 8'h80, 1'b0, 33'h3);
    wr(RCA_IDX_IRQ_STATUS, 8'h03);
    rd(RCA_IDX_IRQ_STATUS, 33'h0);
    give_verdict();
  end
endmodule : rca_top_tb_top
